// ---- shared/spd_pkg.sv ----
// Package: constants and carriers for the serial program/debug entry block
`default_nettype none
package spd_pkg;
	// Link word geometry
	localparam int CMD_W  = 6;
	localparam int DATA_W = 14;
	localparam int CNT_W  = 4;
	localparam logic [CNT_W-1:0] CMD_LAST  = 4'h5;
	localparam logic [CNT_W-1:0] DATA_LAST = 4'hd;
	localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;

	// Program counter and identification words
	localparam logic [DATA_W-1:0] PC_ENTRY = 14'h0000;
	localparam logic [DATA_W-1:0] PC_ONE   = 14'h0001;
	localparam logic [DATA_W-1:0] ID_BASE  = 14'h2000;
	localparam int ID_N    = 4;
	localparam int ID_AW   = 2;
	localparam int ID_KEEP = 7;

	// Configuration word
	localparam int CFG_DEBUG_BIT = 13;
	localparam logic CFG_DEBUG_ON = 1'b0;

	// Indices of the synchronised entry pins
	localparam int PIN_N   = 4;
	localparam int PIN_HV  = 0;
	localparam int PIN_LV  = 1;
	localparam int PIN_CLK = 2;
	localparam int PIN_DAT = 3;

	typedef enum logic [1:0] {M_OFF, M_HV, M_LV, M_DBG} spd_mode_e;
	typedef enum logic {PH_CMD, PH_DATA} spd_phase_e;

	// One finished link transaction
	typedef struct packed {
		logic [CMD_W-1:0]  cmd;
		logic [DATA_W-1:0] data;
		logic              has_data;
		logic              is_read;
	} spd_frame_s;

	localparam int FRAME_W = $bits(spd_frame_s);
endpackage
`default_nettype wire

// ---- rtl/spd_sync3.sv ----
// Three-flop synchroniser with an output flop that changes once the last two stages agree
`default_nettype none
module spd_sync3 #(
	parameter int W = 1
) (
	// Clock and reset of the receiving domain
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Asynchronous input and its clean copy
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] f1;
		logic [W-1:0] f2;
		logic [W-1:0] f3;
		logic [W-1:0] q;
	} spd_sync_s;

	spd_sync_s s_r;
	spd_sync_s s_nxt;

	// First stage feeds only the second; output follows on agreement
	always_comb begin
		s_nxt    = s_r;
		s_nxt.f1 = i_d;
		s_nxt.f2 = s_r.f1;
		s_nxt.f3 = s_r.f2;
		s_nxt.q  = ((s_r.f2 ~^ s_r.f3) & s_r.f2) | ((s_r.f2 ^ s_r.f3) & s_r.q);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_q = s_r.q;
endmodule
`default_nettype wire

// ---- rtl/spd_buf2.sv ----
// Small FIFO with valid/ready on both sides
`default_nettype none
module spd_buf2 #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Filling side
	input  wire logic         i_valid,
	input  wire logic [W-1:0] i_data,
	output logic              o_ready,
	// Draining side
	output logic              o_valid,
	output logic      [W-1:0] o_data,
	input  wire logic         i_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} spd_buf_s;

	spd_buf_s s_r;
	spd_buf_s s_nxt;
	logic     push;
	logic     pop;

	// Depth must be a power of two so the pointers wrap by themselves
	always_comb begin
		s_nxt = s_r;
		push  = i_valid && (s_r.cnt != FULL);
		pop   = i_ready && (s_r.cnt != '0);
		if (push) begin
			s_nxt.mem[s_r.wp] = i_data;
			s_nxt.wp          = s_r.wp + AW'(1);
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + AW'(1);
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_ready = (s_r.cnt != FULL);
	assign o_valid = (s_r.cnt != '0);
	assign o_data  = s_r.mem[s_r.rp];
endmodule
`default_nettype wire

// ---- rtl/spd_entry.sv ----
// Serial program/verify and on-chip debugger entry with its two-wire link
`default_nettype none
// Functional notes
// - Clock and data low while master-clear reaches high level enters program mode.
// - In program mode one pin is serial data, the other serial clock.
// - Program counter is zero on entry, before any command.
// - Every transaction starts with a six-bit command shifted in.
// - A fourteen-bit word follows: driven in for loads, out for reads.
// - Low-voltage enable bit allows entry without high master-clear.
// - With low-voltage enable set, entry pin is not general I/O.
// - Entry pin high with enable set enters program mode.
// - Erased configuration leaves low-voltage enable on.
// - High-voltage entry always works, whatever the enable bit.
// - Enable bit clear returns entry pin to general I/O.
// - Enable bit may change only in a high-voltage session.
// - Enable bit clear refuses low-voltage entry.
// - Debug bit 13 low enables the on-chip debugger.
// - Debugger owns the clock and data pins while enabled.
// - Debugger data and clock lines are bidirectional; here only the data pin is ever driven, the clock output stays released.
// - Four ID words, reachable only in program mode, keep seven bits.
// - Turning code protection off erases all memory.
module spd_entry #(
	parameter logic [63:0] P_LOAD_MAP = 64'h0,
	parameter logic [63:0] P_READ_MAP = 64'h0,
	parameter int          P_LVP_BIT  = 7,
	parameter int          P_CP_BIT   = 6,
	parameter logic        P_CP_ON    = 1'b0
) (
	// System clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	// Link: clock pin clocks the link logic, data pin is two-way
	input  wire logic                        i_prog_clock_pin,
	input  wire logic                        i_prog_data_pin,
	output logic                             o_prog_data_pin,
	output logic                             o_prog_data_oe_n,
	output logic                             o_prog_clock_pin,
	output logic                             o_prog_clock_oe_n,
	// Entry sensing pins
	input  wire logic                        i_hv_entry_level,
	input  wire logic                        i_low_voltage_entry_pin,
	input  wire logic                        i_prog_clock_level,
	// Configuration word and its writes
	input  wire logic [spd_pkg::DATA_W-1:0]  i_cfg_word,
	input  wire logic                        i_cfg_wr,
	input  wire logic [spd_pkg::DATA_W-1:0]  i_cfg_wdata,
	output logic                             o_cfg_wr,
	output logic      [spd_pkg::DATA_W-1:0]  o_cfg_wdata,
	output logic                             o_bulk_erase,
	// Program counter and ID words
	input  wire logic                        i_pc_inc,
	input  wire logic                        i_pc_to_id,
	input  wire logic                        i_id_wr,
	input  wire logic [spd_pkg::DATA_W-1:0]  i_id_wdata,
	output logic      [spd_pkg::DATA_W-1:0]  o_pc,
	output logic      [spd_pkg::DATA_W-1:0]  o_id_rdata,
	// Read word to send on the next read command
	input  wire logic                        i_rd_valid,
	input  wire logic [spd_pkg::DATA_W-1:0]  i_rd_data,
	// Received transactions
	output logic                             o_frame_valid,
	output spd_pkg::spd_frame_s              o_frame,
	input  wire logic                        i_frame_ready,
	output logic                             o_overrun,
	// Mode and pin ownership
	output spd_pkg::spd_mode_e               o_mode,
	output logic                             o_pin3_gpio_en,
	output logic                             o_pin67_gpio_en
);
	typedef struct packed {
		spd_pkg::spd_mode_e                              mode;
		logic                                            hv_prev;
		logic                                            link_hold;
		logic [spd_pkg::DATA_W-1:0]                      pc;
		logic [spd_pkg::ID_N-1:0][spd_pkg::ID_KEEP-1:0]  id;
		logic [spd_pkg::DATA_W-1:0]                      id_rdata;
		logic                                            cfg_wr;
		logic [spd_pkg::DATA_W-1:0]                      cfg_wdata;
		logic                                            erase;
		logic [spd_pkg::DATA_W-1:0]                      rd_word;
		logic                                            rd_tgl;
		logic                                            ack;
		logic                                            ovr_seen;
		logic                                            ovr;
		logic                                            pin3_gpio;
		logic                                            pin67_gpio;
	} spd_sys_s;

	typedef struct packed {
		spd_pkg::spd_phase_e         phase;
		logic [spd_pkg::CNT_W-1:0]   cnt;
		logic [spd_pkg::CMD_W-1:0]   cmd;
		logic [spd_pkg::DATA_W-1:0]  sh;
		logic [spd_pkg::DATA_W-1:0]  rd_hold;
		logic                        rd_seen;
		logic                        has_data;
		logic                        is_read;
		logic                        oe;
		logic                        dout;
		logic                        req;
		logic                        ovr_tgl;
		spd_pkg::spd_frame_s         frame;
	} spd_link_s;

	spd_sys_s                  s_r;
	spd_sys_s                  s_nxt;
	spd_link_s                 l_r;
	spd_link_s                 l_nxt;
	logic [spd_pkg::PIN_N-1:0] pins_s;
	logic                      req_s;
	logic                      ovr_s;
	logic                      rd_tgl_l;
	logic                      link_rst;
	logic                      lvp_en;
	logic                      dbg_en;
	logic                      hv_rise;
	logic                      entry_ok;
	logic                      prog;
	logic                      in_id;
	logic                      push_v;
	logic                      buf_rdy;
	logic                      emit;

	////////////////////////////////////////////////////////////////////////
	// Crossings

	spd_sync3 #(.W(spd_pkg::PIN_N)) u_pin_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_prog_data_pin, i_prog_clock_level, i_low_voltage_entry_pin,
			i_hv_entry_level}),
		.o_q   (pins_s)
	);

	spd_sync3 #(.W(2)) u_tgl_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({l_r.ovr_tgl, l_r.req}),
		.o_q   ({ovr_s, req_s})
	);

	spd_sync3 #(.W(1)) u_rd_sync (
		.i_clk (i_prog_clock_pin),
		.i_rst (link_rst),
		.i_d   (s_r.rd_tgl),
		.o_q   (rd_tgl_l)
	);

	// Link logic is held reset while no session; the link clock is still then
	assign link_rst = i_rst | s_r.link_hold;

	////////////////////////////////////////////////////////////////////////
	// Link domain: command then optional data word, LSB first

	always_comb begin
		l_nxt = l_r;
		emit  = 1'b0;
		// Post the prefetched read word once its toggle has crossed
		if (rd_tgl_l != l_r.rd_seen) begin
			l_nxt.rd_seen = rd_tgl_l;
			l_nxt.rd_hold = s_r.rd_word;
		end
		unique case (l_r.phase)
			spd_pkg::PH_CMD: begin
				l_nxt.cmd = {i_prog_data_pin, l_r.cmd[spd_pkg::CMD_W-1:1]};
				l_nxt.cnt = l_r.cnt + spd_pkg::CNT_ONE;
				if (l_r.cnt == spd_pkg::CMD_LAST) begin
					l_nxt.cnt      = '0;
					l_nxt.is_read  = P_READ_MAP[l_nxt.cmd];
					l_nxt.has_data = P_LOAD_MAP[l_nxt.cmd] | P_READ_MAP[l_nxt.cmd];
					if (l_nxt.has_data) begin
						l_nxt.phase = spd_pkg::PH_DATA;
						l_nxt.sh    = l_nxt.rd_hold;
						l_nxt.oe    = l_nxt.is_read;
						l_nxt.dout  = l_nxt.rd_hold[0];
					end else begin
						emit = 1'b1;
					end
				end
			end
			spd_pkg::PH_DATA: begin
				l_nxt.cnt = l_r.cnt + spd_pkg::CNT_ONE;
				if (l_r.is_read) begin
					l_nxt.sh   = {1'b0, l_r.sh[spd_pkg::DATA_W-1:1]};
					l_nxt.dout = l_r.sh[1];
				end else begin
					l_nxt.sh = {i_prog_data_pin, l_r.sh[spd_pkg::DATA_W-1:1]};
				end
				if (l_r.cnt == spd_pkg::DATA_LAST) begin
					l_nxt.cnt   = '0;
					l_nxt.phase = spd_pkg::PH_CMD;
					l_nxt.oe    = 1'b0;
					emit        = 1'b1;
				end
			end
		endcase
		// Hand the frame over; a frame met by a busy handshake is dropped
		if (emit) begin
			if (l_r.req == s_r.ack) begin
				l_nxt.frame.cmd      = l_nxt.cmd;
				l_nxt.frame.data     = l_r.is_read ? l_r.rd_hold : l_nxt.sh;
				l_nxt.frame.has_data = l_nxt.has_data;
				l_nxt.frame.is_read  = l_nxt.is_read;
				l_nxt.req            = ~l_r.req;
			end else begin
				l_nxt.ovr_tgl = ~l_r.ovr_tgl;
			end
		end
	end

	always_ff @(posedge i_prog_clock_pin or posedge link_rst) begin
		if (link_rst) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// Data pin driven only in the read word; the tool always owns the clock
	assign o_prog_data_pin   = l_r.dout;
	assign o_prog_data_oe_n  = ~l_r.oe;
	assign o_prog_clock_pin  = 1'b0;
	assign o_prog_clock_oe_n = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// System domain: mode, counter, ID words, config writes

	assign lvp_en   = i_cfg_word[P_LVP_BIT];
	assign dbg_en   = (i_cfg_word[spd_pkg::CFG_DEBUG_BIT] == spd_pkg::CFG_DEBUG_ON);
	assign hv_rise  = pins_s[spd_pkg::PIN_HV] & ~s_r.hv_prev;
	assign entry_ok = hv_rise & ~pins_s[spd_pkg::PIN_CLK] & ~pins_s[spd_pkg::PIN_DAT];
	assign prog     = (s_r.mode == spd_pkg::M_HV) || (s_r.mode == spd_pkg::M_LV);
	assign in_id    = (s_r.pc[spd_pkg::DATA_W-1:spd_pkg::ID_AW]
		== spd_pkg::ID_BASE[spd_pkg::DATA_W-1:spd_pkg::ID_AW]);
	assign push_v   = (req_s != s_r.ack) && (s_r.mode != spd_pkg::M_OFF);

	always_comb begin
		s_nxt         = s_r;
		s_nxt.hv_prev = pins_s[spd_pkg::PIN_HV];
		// Entry and exit; from off or debug, high-voltage entry beats every other path
		unique case (s_r.mode)
			spd_pkg::M_OFF, spd_pkg::M_DBG: begin
				if (entry_ok) begin
					s_nxt.mode = spd_pkg::M_HV;
				end else if (lvp_en && pins_s[spd_pkg::PIN_LV]) begin
					s_nxt.mode = spd_pkg::M_LV;
				end else if (dbg_en) begin
					s_nxt.mode = spd_pkg::M_DBG;
				end else begin
					s_nxt.mode = spd_pkg::M_OFF;
				end
			end
			spd_pkg::M_HV: begin
				if (!pins_s[spd_pkg::PIN_HV]) begin
					s_nxt.mode = spd_pkg::M_OFF;
				end
			end
			spd_pkg::M_LV: begin
				if (!pins_s[spd_pkg::PIN_LV] || !lvp_en) begin
					s_nxt.mode = spd_pkg::M_OFF;
				end
			end
		endcase
		s_nxt.link_hold = (s_nxt.mode == spd_pkg::M_OFF);
		// Counter moves only in a session; entry forces it to zero
		if (prog && i_pc_to_id) begin
			s_nxt.pc = spd_pkg::ID_BASE;
		end else if (prog && i_pc_inc) begin
			s_nxt.pc = s_r.pc + spd_pkg::PC_ONE;
		end
		if (!prog && (s_nxt.mode == spd_pkg::M_HV || s_nxt.mode == spd_pkg::M_LV)) begin
			s_nxt.pc = spd_pkg::PC_ENTRY;
		end
		// ID words live outside normal execution; upper bits dropped
		if (prog && in_id && i_id_wr) begin
			s_nxt.id[s_r.pc[spd_pkg::ID_AW-1:0]] = i_id_wdata[spd_pkg::ID_KEEP-1:0];
		end
		s_nxt.id_rdata = (prog && in_id) ? {{(spd_pkg::DATA_W-spd_pkg::ID_KEEP){1'b0}},
			s_r.id[s_r.pc[spd_pkg::ID_AW-1:0]]} : '0;
		// Config write keeps the enable bit unless high voltage was used
		s_nxt.cfg_wr    = prog && i_cfg_wr;
		s_nxt.cfg_wdata = i_cfg_wdata;
		if (s_r.mode != spd_pkg::M_HV) begin
			s_nxt.cfg_wdata[P_LVP_BIT] = lvp_en;
		end
		s_nxt.erase = prog && i_cfg_wr && (i_cfg_word[P_CP_BIT] == P_CP_ON)
			&& (i_cfg_wdata[P_CP_BIT] != P_CP_ON);
		// Read word posted by the core, announced by a toggle
		if (i_rd_valid) begin
			s_nxt.rd_word = i_rd_data;
			s_nxt.rd_tgl  = ~s_r.rd_tgl;
		end
		// Frame taken when the buffer has room; stalling keeps the link busy
		if (req_s != s_r.ack && (buf_rdy || s_r.mode == spd_pkg::M_OFF)) begin
			s_nxt.ack = req_s;
		end
		s_nxt.ovr_seen   = ovr_s;
		s_nxt.ovr        = (ovr_s != s_r.ovr_seen);
		s_nxt.pin3_gpio  = ~lvp_en;
		s_nxt.pin67_gpio = ~dbg_en && (s_nxt.mode == spd_pkg::M_OFF);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r           <= '0;
			s_r.link_hold <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	spd_buf2 #(.W(spd_pkg::FRAME_W), .DEPTH(2)) u_buf (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_valid (push_v),
		.i_data  (l_r.frame),
		.o_ready (buf_rdy),
		.o_valid (o_frame_valid),
		.o_data  (o_frame),
		.i_ready (i_frame_ready)
	);

	assign o_pc            = s_r.pc;
	assign o_id_rdata      = s_r.id_rdata;
	assign o_cfg_wr        = s_r.cfg_wr;
	assign o_cfg_wdata     = s_r.cfg_wdata;
	assign o_bulk_erase    = s_r.erase;
	assign o_overrun       = s_r.ovr;
	assign o_mode          = s_r.mode;
	assign o_pin3_gpio_en  = s_r.pin3_gpio;
	assign o_pin67_gpio_en = s_r.pin67_gpio;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_hv_entry;
		@(posedge i_clk) disable iff (i_rst)
		(s_r.mode == spd_pkg::M_OFF || s_r.mode == spd_pkg::M_DBG) && entry_ok
			|=> s_r.mode == spd_pkg::M_HV;
	endproperty
	a_hv_entry: assert property (p_hv_entry) else $error("high-voltage entry missed");

	property p_pc_zero;
		@(posedge i_clk) disable iff (i_rst)
		!prog ##1 prog |-> s_r.pc == spd_pkg::PC_ENTRY;
	endproperty
	a_pc_zero: assert property (p_pc_zero) else $error("counter not zero at entry");

	property p_lv_entry;
		@(posedge i_clk) disable iff (i_rst)
		s_r.mode == spd_pkg::M_OFF && !entry_ok && lvp_en && pins_s[spd_pkg::PIN_LV]
			|=> s_r.mode == spd_pkg::M_LV;
	endproperty
	a_lv_entry: assert property (p_lv_entry) else $error("low-voltage entry missed");

	property p_lv_reject;
		@(posedge i_clk) disable iff (i_rst)
		!lvp_en |=> s_r.mode != spd_pkg::M_LV;
	endproperty
	a_lv_reject: assert property (p_lv_reject) else $error("low-voltage entry not refused");

	property p_pin3;
		@(posedge i_clk) disable iff (i_rst)
		$changed(lvp_en) |=> o_pin3_gpio_en == !$past(lvp_en);
	endproperty
	a_pin3: assert property (p_pin3) else $error("entry pin ownership wrong");

	property p_lvp_lock;
		@(posedge i_clk) disable iff (i_rst)
		i_cfg_wr && s_r.mode == spd_pkg::M_LV
			|=> o_cfg_wr && o_cfg_wdata[P_LVP_BIT] == $past(lvp_en);
	endproperty
	a_lvp_lock: assert property (p_lvp_lock) else $error("enable bit changed outside HV");

	property p_dbg_pins;
		@(posedge i_clk) disable iff (i_rst)
		s_r.mode == spd_pkg::M_DBG |-> !o_pin67_gpio_en;
	endproperty
	a_dbg_pins: assert property (p_dbg_pins) else $error("debug pins left to I/O");

	property p_erase;
		@(posedge i_clk) disable iff (i_rst)
		prog && i_cfg_wr && i_cfg_word[P_CP_BIT] == P_CP_ON && i_cfg_wdata[P_CP_BIT] != P_CP_ON
			|=> o_bulk_erase ##1 !o_bulk_erase;
	endproperty
	a_erase: assert property (p_erase) else $error("bulk erase not pulsed");

	property p_id7;
		@(posedge i_clk) disable iff (i_rst)
		(o_id_rdata[spd_pkg::DATA_W-1:spd_pkg::ID_KEEP] == '0) and (!prog |=> o_id_rdata == '0);
	endproperty
	a_id7: assert property (p_id7) else $error("ID word wider than kept");

	property p_read_oe;
		@(posedge i_prog_clock_pin) disable iff (link_rst)
		!o_prog_data_oe_n |-> l_r.phase == spd_pkg::PH_DATA && l_r.is_read;
	endproperty
	a_read_oe: assert property (p_read_oe) else $error("data pin driven outside read");

	c_hv: cover property (@(posedge i_clk) disable iff (i_rst) s_r.mode == spd_pkg::M_HV);
	c_lv: cover property (@(posedge i_clk) disable iff (i_rst) s_r.mode == spd_pkg::M_LV);
	c_frame: cover property (@(posedge i_clk) disable iff (i_rst)
		o_frame_valid && i_frame_ready && o_frame.is_read);
endmodule
`default_nettype wire

// ---- dv/spd_tool.sv ----
// Programmer tool model: entry levels and the two-wire link
`default_nettype none
module spd_tool (
	// Device side of the data pin
	input  wire logic i_dev_data,
	input  wire logic i_dev_oe_n,
	// Pin levels seen by the device
	output logic      o_clk,
	output logic      o_dat,
	output logic      o_hv,
	output logic      o_lv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv = 1'b0;
	// Wire level, device wins while it drives
	assign o_dat = i_dev_oe_n ? drv : i_dev_data;
	// Clock idles low between frames
	initial begin
		o_clk = 1'b0;
		o_hv = 1'b0;
		o_lv = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// Entry levels, applied away from any clock edge
	task automatic pins(input logic hv, input logic lv, input logic d);
		drv = d;
		o_hv = hv;
		o_lv = lv;
	endtask
	// One frame, LSB first, 64 ns period; read bits taken on falling edges
	task automatic xfer(input logic [5:0] c, input logic [13:0] d, input int n,
		output logic [13:0] rd);
		rd = 14'h0000;
		for (int k = 0; k < 6 + n; k++) begin
			drv = (k < 6) ? c[k] : d[k-6];
			#32 o_clk = 1'b1;
			#32 o_clk = 1'b0;
			if (k >= 5 && k < 19) rd[k-5] = o_dat;
		end
		// Released line flips so a stale level is never mistaken for data
		drv = ~drv;
	endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Testbench: entry modes, link frames, buffer stall and config filters
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [5:0] LD = 6'h02;
	localparam logic [5:0] RD = 6'h04;
	// Design inputs
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic [13:0]         cfg = 14'h2080;
	logic                cwr = 1'b0;
	logic [13:0]         cwd = 14'h0000;
	logic                pinc = 1'b0;
	logic                pid = 1'b0;
	logic                iwr = 1'b0;
	logic [13:0]         iwd = 14'h0000;
	logic                rdv = 1'b0;
	logic [13:0]         rdd = 14'h0000;
	logic                frdy = 1'b0;
	// Pins, outputs and bookkeeping
	wire logic           lclk, ldat, hv, lv;
	logic                dpin, doe_n, ckoe, ckp, owr, ers, fv, ovr, g3, g67;
	logic [13:0]         owd, pc, idr;
	spd_pkg::spd_frame_s fr;
	spd_pkg::spd_mode_e  mode;
	spd_pkg::spd_frame_s exp_q[$];
	int                  num_errors = 0;
	int                  comparisons = 0;
	int                  n_ovr = 0;
	int                  n_ers = 0;
	////////////////////////////////////////////////////////////////////////////
	spd_tool i_spd_tool (.i_dev_data(dpin), .i_dev_oe_n(doe_n), .o_clk(lclk), .o_dat(ldat),
		.o_hv(hv), .o_lv(lv));
	spd_entry #(.P_LOAD_MAP(64'h4), .P_READ_MAP(64'h10)) i_spd_entry (
		.i_clk(clk), .i_rst(rst), .i_prog_clock_pin(lclk), .i_prog_data_pin(ldat),
		.o_prog_data_pin(dpin), .o_prog_data_oe_n(doe_n), .o_prog_clock_pin(ckp),
		.o_prog_clock_oe_n(ckoe), .i_hv_entry_level(hv), .i_low_voltage_entry_pin(lv),
		.i_prog_clock_level(lclk), .i_cfg_word(cfg), .i_cfg_wr(cwr), .i_cfg_wdata(cwd),
		.o_cfg_wr(owr), .o_cfg_wdata(owd), .o_bulk_erase(ers), .i_pc_inc(pinc),
		.i_pc_to_id(pid), .i_id_wr(iwr), .i_id_wdata(iwd), .o_pc(pc), .o_id_rdata(idr),
		.i_rd_valid(rdv), .i_rd_data(rdd), .o_frame_valid(fv), .o_frame(fr),
		.i_frame_ready(frdy), .o_overrun(ovr), .o_mode(mode), .o_pin3_gpio_en(g3),
		.o_pin67_gpio_en(g67));
	// 10 MHz system clock
	initial begin
		forever #50 clk = ~clk;
	end
	// Count one-cycle pulses so later checks need no exact cycle
	always @(posedge clk) begin
		if (ovr === 1'b1) n_ovr++;
		if (ers === 1'b1) n_ers++;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Expected frame: only load and read commands carry a word
	function automatic spd_pkg::spd_frame_s exp_frame(input logic [5:0] c, input logic [13:0] d);
		logic hd;
		hd = (c == LD) || (c == RD);
		return {c, hd ? d : 14'h0000, hd, c == RD};
	endfunction
	// Bounded wait for a mode; a miss ends the run
	task automatic wmode(input spd_pkg::spd_mode_e m);
		int i;
		for (i = 0; i < 12 && mode !== m; i++) @(negedge clk);
		chk(mode, m);
		if (mode !== m) stop_test();
	endtask
	// Send one frame; reads post their word first and check what came back
	task automatic frame(input logic [5:0] c, input logic [13:0] d);
		logic [13:0] rd;
		int n;
		n = (c == LD || c == RD) ? 14 : 0;
		@(posedge clk);
		rdv <= (c == RD);
		rdd <= d;
		@(posedge clk);
		rdv <= 1'b0;
		// Tool drives the inverse under a read, so an echo of its own level fails
		#13 i_spd_tool.xfer(c, (c == RD) ? ~d : d, n, rd);
		if (c == RD) chk(rd, d);
		exp_q.push_back(exp_frame(c, d));
	endtask
	// Take one frame; data is ignored on command-only frames
	task automatic take();
		spd_pkg::spd_frame_s e;
		logic [21:0] m;
		int i;
		for (i = 0; i < 40 && fv !== 1'b1; i++) @(negedge clk);
		chk(fv, 1'b1);
		if (fv !== 1'b1) stop_test();
		e = exp_q.pop_front();
		m = e.has_data ? 22'h3fffff : 22'h3f0003;
		chk(fr & m, e & m);
		@(posedge clk);
		frdy <= 1'b1;
		@(posedge clk);
		frdy <= 1'b0;
		@(negedge clk);
	endtask
	task automatic cfgw(input logic [13:0] d);
		@(posedge clk);
		cwr <= 1'b1;
		cwd <= d;
		@(posedge clk);
		cwr <= 1'b0;
		@(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int s;
		int kept;
		void'($urandom(32'h2e646ae7));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// Pin ownership flops load on the first edge after release
		repeat (2) @(negedge clk);
		chk(mode, spd_pkg::M_OFF);
		chk({g3, g67, ckoe, ckp}, 4'b0110);
		// Data high during the rise is refused, clean rise enters
		i_spd_tool.pins(1'b1, 1'b0, 1'b1);
		repeat (12) @(negedge clk);
		chk(mode, spd_pkg::M_OFF);
		i_spd_tool.pins(1'b0, 1'b0, 1'b0);
		repeat (8) @(negedge clk);
		i_spd_tool.pins(1'b1, 1'b0, 1'b0);
		wmode(spd_pkg::M_HV);
		chk(pc, 14'h0000);
		// ID word keeps seven bits, counter steps
		@(posedge clk);
		pid <= 1'b1;
		@(posedge clk);
		pid <= 1'b0;
		iwr <= 1'b1;
		iwd <= 14'h3fff;
		@(posedge clk);
		iwr <= 1'b0;
		repeat (2) @(negedge clk);
		chk({pc, idr}, {14'h2000, 14'h007f});
		@(posedge clk);
		pinc <= 1'b1;
		@(posedge clk);
		pinc <= 1'b0;
		@(negedge clk);
		chk(pc, 14'h2001);
		// Corner words, then random commands of all three kinds
		repeat (8) @(posedge clk);
		frame(LD, 14'h3fff);
		take();
		frame(RD, 14'h2aaa);
		take();
		for (int k = 0; k < 10; k++) begin
			s = $urandom_range(2);
			frame(s == 0 ? LD : s == 1 ? RD : {1'b1, 5'($urandom)}, 14'($urandom));
			take();
		end
		// Receiver stalls: stored words survive, extra frames drop with a flag
		for (int k = 0; k < 4; k++) begin
			s = n_ovr;
			frame(LD, 14'($urandom));
			repeat (20) @(negedge clk);
			if (n_ovr != s) void'(exp_q.pop_back());
		end
		chk(n_ovr > 0, 1'b1);
		kept = exp_q.size();
		chk(kept >= 2, 1'b1);
		repeat (kept) take();
		chk(fv, 1'b0);
		// Lifting protection erases; enable bit may drop in this session
		cfgw(14'h20c0);
		chk({owr, owd}, {1'b1, 14'h20c0});
		cfgw(14'h2000);
		chk(owd, 14'h2000);
		repeat (2) @(negedge clk);
		chk(n_ers, 1);
		@(posedge clk);
		cfg <= 14'h20c0;
		i_spd_tool.pins(1'b0, 1'b0, 1'b0);
		wmode(spd_pkg::M_OFF);
		// Low-voltage session keeps the enable bit
		i_spd_tool.pins(1'b0, 1'b1, 1'b0);
		wmode(spd_pkg::M_LV);
		cfgw(14'h2040);
		chk(owd, 14'h20c0);
		i_spd_tool.pins(1'b0, 1'b0, 1'b0);
		wmode(spd_pkg::M_OFF);
		// Enable cleared: pin is general I/O and entry is refused
		@(posedge clk);
		cfg <= 14'h2040;
		repeat (3) @(negedge clk);
		chk(g3, 1'b1);
		i_spd_tool.pins(1'b0, 1'b1, 1'b0);
		repeat (12) @(negedge clk);
		chk(mode, spd_pkg::M_OFF);
		i_spd_tool.pins(1'b0, 1'b0, 1'b0);
		// Debug bit low takes the link pins
		@(posedge clk);
		cfg <= 14'h0040;
		wmode(spd_pkg::M_DBG);
		repeat (2) @(negedge clk);
		chk(g67, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
